//--- rtl/sn_slave_regs.svh
// Timing constants and fixed codes for the serial number slave
`ifndef SN_SLAVE_REGS_SVH
`define SN_SLAVE_REGS_SVH

// System clock rate in MHz, cycles per microsecond
`define SN_CLK_MHZ 200

// Reset low interval lower bounds, microseconds
`define SN_RESET_LOW_STD_US 480
`define SN_RESET_LOW_FAST_US 60

// Write sample point after the falling edge, microseconds
`define SN_WRITE_SAMPLE_STD_US 30
`define SN_WRITE_SAMPLE_FAST_US 3

// Read zero hold time after the falling edge, microseconds
`define SN_READ_HOLD_STD_US 30
`define SN_READ_HOLD_FAST_US 3

// Presence wait interval after the line rises, microseconds
`define SN_PRESENCE_WAIT_STD_US 30
`define SN_PRESENCE_WAIT_FAST_US 3

// Presence low interval, microseconds
`define SN_PRESENCE_LOW_STD_US 120
`define SN_PRESENCE_LOW_FAST_US 16

// Command bytes
`define SN_CMD_READ_NUMBER 8'h33
`define SN_CMD_FAST_SKIP 8'h3c

// Registration number layout
`define SN_NUMBER_BITS 7'h40
`define SN_CMD_BITS 4'h8
`define SN_CRC_POLY 8'h8c
`define SN_CRC_INIT 8'h00

// Timer width and saturation value
`define SN_TIMER_MAX 17'h1ffff

`endif

//--- rtl/sn_slave_pkg.sv
// Types shared by the serial number slave
package sn_slave_pkg;

  // Line phase of the slave
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_LOW,
    PH_PRES_WAIT,
    PH_PRES_LOW
  } phase_t;

  // Protocol layer after a presence
  typedef enum logic [1:0] {
    MD_COMMAND,
    MD_READ,
    MD_SILENT
  } mode_t;

  // Open-drain pin drive pair
  typedef struct packed {
    logic out;  // Level driven when enabled, always low
    logic oe;   // High while the slave pulls the line
  } od_pin_t;

  // Entire state of the slave
  typedef struct packed {
    phase_t phase;      // Line phase
    mode_t mode;        // Protocol layer
    logic [16:0] timer; // Cycles since the last timing event
    logic fast;         // Overdrive timing in use
    logic [7:0] cmd;    // Command shift register
    logic [6:0] bits;   // Bits taken or sent in this protocol layer
    logic drive;        // Pull the line low
  } slave_state_t;

endpackage

//--- rtl/single_wire_serial_number_slave.sv
// Open-drain single-wire slave returning a fixed 64-bit number
`timescale 1ns/1ps
`include "sn_slave_regs.svh"

module single_wire_serial_number_slave
  import sn_slave_pkg::*;
#(
  // Family code, arbitrary neutral value
  parameter logic [7:0] FAMILY_CODE = 8'h5a,
  // Serial number, arbitrary neutral value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0000_1234_5678,
  // Long counts, shortened in simulation if wanted
  parameter logic [16:0] RESET_STD_CYC =
    17'(`SN_RESET_LOW_STD_US * `SN_CLK_MHZ),
  parameter logic [16:0] RESET_FAST_CYC =
    17'(`SN_RESET_LOW_FAST_US * `SN_CLK_MHZ),
  parameter logic [16:0] SAMPLE_STD_CYC =
    17'(`SN_WRITE_SAMPLE_STD_US * `SN_CLK_MHZ),
  parameter logic [16:0] HOLD_STD_CYC =
    17'(`SN_READ_HOLD_STD_US * `SN_CLK_MHZ),
  parameter logic [16:0] PWAIT_STD_CYC =
    17'(`SN_PRESENCE_WAIT_STD_US * `SN_CLK_MHZ),
  parameter logic [16:0] PLOW_STD_CYC =
    17'(`SN_PRESENCE_LOW_STD_US * `SN_CLK_MHZ)
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic line_in,       // Sampled level of the data line
  output od_pin_t line_pin,       // Open-drain drive of the data line
  output logic fast_speed_flag    // Overdrive timing active
);

  // Short overdrive counts, all below the parameter limit
  localparam logic [16:0] SAMPLE_FAST_CYC =
    17'(`SN_WRITE_SAMPLE_FAST_US * `SN_CLK_MHZ);
  localparam logic [16:0] HOLD_FAST_CYC =
    17'(`SN_READ_HOLD_FAST_US * `SN_CLK_MHZ);
  localparam logic [16:0] PWAIT_FAST_CYC =
    17'(`SN_PRESENCE_WAIT_FAST_US * `SN_CLK_MHZ);
  localparam logic [16:0] PLOW_FAST_CYC =
    17'(`SN_PRESENCE_LOW_FAST_US * `SN_CLK_MHZ);

  // Reflected CRC, fed least significant bit first
  function automatic logic [7:0] crc8(input logic [55:0] data);
    logic [7:0] crc;
    logic feedback;
    crc = `SN_CRC_INIT;
    for (int i = 0; i < 56; i++)
    begin
      feedback = crc[0] ^ data[i];
      crc = {1'b0, crc[7:1]};
      if (feedback)
      begin
        crc = crc ^ `SN_CRC_POLY;
      end
    end
    return crc;
  endfunction

  // Choose the count for the current speed
  function automatic logic [16:0] pick(input logic fast,
                                       input logic [16:0] fast_cyc,
                                       input logic [16:0] std_cyc);
    return fast ? fast_cyc : std_cyc;
  endfunction

  // Fixed registration number, family in the low byte
  localparam logic [7:0] NUMBER_CRC =
    crc8({SERIAL_NUMBER, FAMILY_CODE});
  localparam logic [63:0] NUMBER =
    {NUMBER_CRC, SERIAL_NUMBER, FAMILY_CODE};

  slave_state_t s;       // Registered state
  slave_state_t next_s;  // Next state
  logic [16:0] next_timer_inc; // Saturating timer increment
  logic number_bit;      // Number bit due in the next read slot
  logic reset_seen;      // Ended low period was a reset

  // Saturating timer and current output bit
  always_comb
  begin
    next_timer_inc = (s.timer == `SN_TIMER_MAX) ? s.timer
                                                : s.timer + 17'h00001;
    number_bit = NUMBER[s.bits[5:0]];
    reset_seen = (s.timer >= pick(s.fast, RESET_FAST_CYC,
                                  RESET_STD_CYC));
  end

  // Next state of the slave
  always_comb
  begin
    next_s = s;
    case (s.phase)
      // Line released, wait for the master to pull low
      PH_IDLE:
      begin
        if (!line_in)
        begin
          next_s.phase = PH_LOW;
          next_s.timer = 17'h00000;
          // Read zero starts pulling right at the edge
          next_s.drive = (s.mode == MD_READ) && !number_bit;
        end
      end
      // Line low, measure and serve the slot
      PH_LOW:
      begin
        next_s.timer = next_timer_inc;
        // End the read-zero pull after the hold time
        if (s.timer >= pick(s.fast, HOLD_FAST_CYC, HOLD_STD_CYC)
                       - 17'h00001)
        begin
          next_s.drive = 1'b0;
        end
        // Low too long for a write one: leave the bit as zero
        if (s.mode == MD_COMMAND &&
            s.timer == pick(s.fast, SAMPLE_FAST_CYC, SAMPLE_STD_CYC))
        begin
          next_s.cmd = {line_in, s.cmd[7:1]};
          next_s.bits = s.bits + 7'h01;
        end
        // Line released by master and by us
        if (line_in && !s.drive)
        begin
          next_s.drive = 1'b0;
          next_s.timer = 17'h00000;
          if (reset_seen)
          begin
            next_s.phase = PH_PRES_WAIT;
            next_s.mode = MD_COMMAND;
            next_s.bits = 7'h00;
            if (s.timer >= RESET_STD_CYC)
            begin
              next_s.fast = 1'b0;
            end
          end
          else
          begin
            next_s.phase = PH_IDLE;
            // Released before the sample point: a written one
            if (s.mode == MD_COMMAND &&
                s.timer < pick(s.fast, SAMPLE_FAST_CYC, SAMPLE_STD_CYC))
            begin
              next_s.cmd = {1'b1, s.cmd[7:1]};
              next_s.bits = s.bits + 7'h01;
            end
            // Decode a completed command byte, last bit included
            if (s.mode == MD_COMMAND &&
                next_s.bits == 7'(`SN_CMD_BITS))
            begin
              next_s.bits = 7'h00;
              if (next_s.cmd == `SN_CMD_READ_NUMBER)
              begin
                next_s.mode = MD_READ;
              end
              else if (next_s.cmd == `SN_CMD_FAST_SKIP)
              begin
                next_s.mode = MD_SILENT;
                next_s.fast = 1'b1;
              end
              else
              begin
                next_s.mode = MD_SILENT;
              end
            end
            // Step to the next number bit after each read slot
            else if (s.mode == MD_READ)
            begin
              next_s.bits = s.bits + 7'h01;
              if (s.bits == `SN_NUMBER_BITS - 7'h01)
              begin
                next_s.mode = MD_SILENT;
              end
            end
          end
        end
      end
      // Line high after a reset, wait before presence
      PH_PRES_WAIT:
      begin
        next_s.timer = next_timer_inc;
        if (s.timer >= pick(s.fast, PWAIT_FAST_CYC, PWAIT_STD_CYC)
                       - 17'h00001)
        begin
          next_s.phase = PH_PRES_LOW;
          next_s.timer = 17'h00000;
          next_s.drive = 1'b1;
        end
      end
      // Presence pulse, pull the line low
      PH_PRES_LOW:
      begin
        next_s.timer = next_timer_inc;
        if (s.timer >= pick(s.fast, PLOW_FAST_CYC, PLOW_STD_CYC)
                       - 17'h00001)
        begin
          next_s.phase = PH_IDLE;
          next_s.timer = 17'h00000;
          next_s.drive = 1'b0;
        end
      end
      // Unreachable encoding, back to idle
      default:
      begin
        next_s.phase = PH_IDLE;
        next_s.drive = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Silent and idle, no presence until a real bus reset
      s <= '{phase: PH_IDLE, mode: MD_SILENT, timer: 17'h00000,
             fast: 1'b0, cmd: 8'h00, bits: 7'h00, drive: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Open-drain drive: only ever pulls low, slave never opens slots
  assign line_pin.out = 1'b0;
  assign line_pin.oe = s.drive;
  assign fast_speed_flag = s.fast;

endmodule

//--- tb/sn_slave_checker.sv
// Pin-level checker for the serial number slave
`timescale 1ns/1ps
module sn_slave_checker
  import sn_slave_pkg::*;
#(
  parameter logic [16:0] RESET_STD_CYC = 17'h7d0,
  parameter logic [16:0] RESET_FAST_CYC = 17'h3e8,
  parameter logic [16:0] HOLD_STD_CYC = 17'h14,
  parameter logic [16:0] PWAIT_STD_CYC = 17'h14,
  parameter logic [16:0] PLOW_STD_CYC = 17'h3c
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic line_in,
  input wire od_pin_t line_pin,
  input wire logic fast_speed_flag
);
  logic [16:0] low_cnt, last_run, hi_cnt, oe_run; // Run lengths
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Count line lows, highs and own drive
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      low_cnt <= '0;
      last_run <= '0;
      hi_cnt <= '0;
      oe_run <= '0;
    end
    else
    begin
      low_cnt <= line_in ? 17'h0 : low_cnt + 17'h1;
      hi_cnt <= line_in ? hi_cnt + 17'h1 : 17'h0;
      oe_run <= line_pin.oe ? oe_run + 17'h1 : 17'h0;
      if (line_in && low_cnt != 17'h0)
        last_run <= low_cnt;
    end
  // Master fall seen: line high, then low on the next cycle
  sequence fall_seen;
    line_in ##1 !line_in;
  endsequence
  chk_out_low: assert property (line_pin.out == 1'b0)
    else $error("pin level not low");
  chk_pres_cause: assert property ($rose(line_pin.oe) && $past(line_in)
    |-> last_run >= RESET_FAST_CYC && hi_cnt inside
    {[PWAIT_STD_CYC - 17'h1:PWAIT_STD_CYC + 17'h4], [17'h256:17'h25c]})
    else $error("presence without reset or off time");
  chk_zero_quick: assert property ($rose(line_pin.oe) && !$past(line_in)
    |-> low_cnt <= 17'h3)
    else $error("read zero late");
  chk_zero_hold: assert property (fall_seen ##[1:3] line_pin.oe
    |-> line_pin.oe[*8])
    else $error("drive too short");
  chk_drive_len: assert property ($fell(line_pin.oe) |-> oe_run inside
    {[HOLD_STD_CYC - 17'h1:HOLD_STD_CYC + 17'h1],
    [PLOW_STD_CYC - 17'h1:PLOW_STD_CYC + 17'h1],
    [17'h257:17'h259], [17'hc7f:17'hc81]})
    else $error("drive length wrong");
  chk_drive_bound: assert property (oe_run <= 17'hc81)
    else $error("drive stuck");
  chk_fast_clear: assert property ($fell(fast_speed_flag)
    |-> low_cnt >= RESET_STD_CYC - 17'h1 || last_run >= RESET_STD_CYC - 17'h1)
    else $error("speed cleared without long reset");
  chk_fast_set: assert property ($rose(fast_speed_flag)
    |-> last_run < RESET_FAST_CYC)
    else $error("speed set by a reset");
endmodule

//--- tb/sn_bus_master.sv
// Bus master model pulling the shared line through an open drain
`timescale 1ns/1ps
module sn_bus_master (
  input wire logic clk_sys,
  input wire logic line_in,
  output logic pull
);
  // Released from the start, line idles high
  initial pull = 1'b0;
  // Low for n cycles, then released r cycles
  task automatic low(input int n, input int r);
    @(posedge clk_sys) pull <= 1'b1;
    repeat (n) @(posedge clk_sys);
    pull <= 1'b0;
    repeat (r) @(posedge clk_sys);
  endtask
  // Reset pulse, presence sampled s cycles after release
  task automatic rst(input int n, input int s, output logic p);
    low(n, s);
    p = line_in;
    repeat (s * 4) @(posedge clk_sys);
  endtask
  // Command byte, least significant bit first
  task automatic wr(input logic [7:0] b, input int w1, input int w0);
    for (int i = 0; i < 8; i++)
      low(b[i] ? w1 : w0, w1 + 40);
  endtask
  // Read slots, sampled s cycles after release
  task automatic rd(input int n, input int l, input int s,
    output logic [64:0] v);
    v = '1;
    for (int i = 0; i < n; i++)
    begin
      low(l, s);
      v[i] = line_in;
      repeat (s * 14) @(posedge clk_sys);
    end
  endtask
endmodule

//--- tb/tb_single_wire_serial_number_slave.sv
// Testbench for the serial number slave
`timescale 1ns/1ps
module tb_single_wire_serial_number_slave;
  import sn_slave_pkg::*;
  localparam logic [7:0] FAM = 8'ha5; // Arbitrary value
  localparam logic [47:0] SER = 48'h0badcafe0123; // Arbitrary value
  localparam logic [16:0] RST_STD_CYC = 17'h007d0; // Shortened long reset
  localparam logic [16:0] RST_FAST_CYC = 17'h003e8; // Shortened fast reset
  localparam logic [16:0] SMP_STD_CYC = 17'h00014; // Write sample point
  localparam logic [16:0] HLD_STD_CYC = 17'h00014; // Read zero hold
  localparam logic [16:0] PWT_STD_CYC = 17'h00014; // Presence wait
  localparam logic [16:0] PLW_STD_CYC = 17'h0003c; // Presence low
  typedef struct packed {
    logic [7:0] cmd;
    logic fst;
    logic [64:0] num;
  } row_t;
  row_t rows [3]; // Command, flag, read bits
  logic clk_sys, rst_n, pull, fast, p;
  wire logic line_in;
  od_pin_t pin;
  logic [64:0] v, num;
  int num_errors, num_checks;
  // Wired-AND with the pull-up
  assign line_in = !(pull || (pin.oe && !pin.out));
  single_wire_serial_number_slave #(
    .FAMILY_CODE(FAM), .SERIAL_NUMBER(SER),
    .RESET_STD_CYC(RST_STD_CYC), .RESET_FAST_CYC(RST_FAST_CYC),
    .SAMPLE_STD_CYC(SMP_STD_CYC), .HOLD_STD_CYC(HLD_STD_CYC),
    .PWAIT_STD_CYC(PWT_STD_CYC), .PLOW_STD_CYC(PLW_STD_CYC)
  ) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(line_in),
    .line_pin(pin), .fast_speed_flag(fast));
  sn_bus_master m (.clk_sys(clk_sys), .line_in(line_in), .pull(pull));
  // Check byte, reflected, least significant bit first
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction
  // Compare one flag
  task automatic cb(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Compare read bits
  task automatic cn(input string n, input logic [64:0] e,
    input logic [64:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Hang guard, about twice the expected run of some 43500 cycles
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    stop_test;
  end
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    num_errors = 0;
    num_checks = 0;
    num = {1'b1, crc8({SER, FAM}), SER, FAM};
    rows[0] = '{8'h33, 1'b0, num};
    rows[1] = '{8'h3c, 1'b1, '1};
    rows[2] = '{8'h99, 1'b0, '1};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      m.rst(2100, 40, p);
      cb("presence", 1'b0, p);
      m.wr(rows[i].cmd, 5, 40);
      m.rd(65, 3, 4, v);
      cn("number", rows[i].num, v);
      cb("speed", rows[i].fst, fast);
    end
    // Short reset at fast speed, then a fast read
    m.rst(2100, 40, p);
    m.wr(8'h3c, 5, 40);
    m.rst(1200, 1000, p);
    cb("fast presence", 1'b0, p);
    cb("speed kept", 1'b1, fast);
    m.wr(8'h33, 100, 800);
    m.rd(8, 50, 50, v);
    cn("fast family", {{57{1'b1}}, FAM}, v);
    m.rst(2100, 40, p);
    cb("speed back", 1'b0, fast);
    cb("slow presence", 1'b0, p);
    stop_test;
  end
endmodule
bind single_wire_serial_number_slave sn_slave_checker #(
  .RESET_STD_CYC(RESET_STD_CYC), .RESET_FAST_CYC(RESET_FAST_CYC),
  .HOLD_STD_CYC(HOLD_STD_CYC), .PWAIT_STD_CYC(PWAIT_STD_CYC),
  .PLOW_STD_CYC(PLOW_STD_CYC)
) chk (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(line_in),
  .line_pin(line_pin), .fast_speed_flag(fast_speed_flag));
